// ==== verilog/uwlm_pkg.sv ====
// Shared constants for the partial-word load merge unit.
// Assumes a 32-bit APB register bus and a 32-bit aligned memory word.
package uwlm_pkg;

  // Operation codes presented by the pipeline
  typedef enum logic [1:0] {
    UWLM_OP_LEFT      = 2'h0,  // left_partial_word_load
    UWLM_OP_RIGHT     = 2'h1,  // right_partial_word_load
    UWLM_OP_USER_LEFT = 2'h2   // user_map_left_partial_load
  } uwlm_op_type;

  // Segment access modes reported by address translation
  localparam logic [2:0] UWLM_SEG_MAPPED_USER  = 3'h1;
  localparam logic [2:0] UWLM_SEG_UNMAPPED_USR = 3'h2;
  localparam logic [2:0] UWLM_SEG_MAPPED_SUPV  = 3'h3;

  // Exception codes on the result port
  localparam logic [3:0] UWLM_EXC_NONE      = 4'h0;
  localparam logic [3:0] UWLM_EXC_TLB_REFL  = 4'h1;
  localparam logic [3:0] UWLM_EXC_TLB_INVL  = 4'h2;
  localparam logic [3:0] UWLM_EXC_BUS_ERR   = 4'h3;
  localparam logic [3:0] UWLM_EXC_ADDR_ERR  = 4'h4;
  localparam logic [3:0] UWLM_EXC_WATCH     = 4'h5;
  localparam logic [3:0] UWLM_EXC_RSVD_INST = 4'h6;
  localparam logic [3:0] UWLM_EXC_COP_UNUSE = 4'h7;

  // Widths of the immediate offsets
  localparam int UWLM_OFS_W      = 16;
  localparam int UWLM_USER_OFS_W = 9;

  // Register byte addresses
  localparam logic [7:0] UWLM_ADDR_CTRL   = 8'h00;
  localparam logic [7:0] UWLM_ADDR_STATUS = 8'h04;
  localparam logic [7:0] UWLM_ADDR_IRQ_EN = 8'h08;
  localparam logic [7:0] UWLM_ADDR_CLEAR  = 8'h0c;
  localparam logic [7:0] UWLM_ADDR_LAST   = 8'h10;
  localparam logic [7:0] UWLM_ADDR_CONFIG = 8'h14;

  // Control fields and reset values
  localparam int         UWLM_CTRL_EN_BIT  = 0;
  localparam int         UWLM_CTRL_BIG_BIT = 1;
  localparam logic       UWLM_CTRL_EN_RST  = 1'b1;
  localparam logic       UWLM_CTRL_BIG_RST = 1'b1;

  // Event bits of status, clear and enable registers
  localparam int UWLM_EV_N        = 8;
  localparam int UWLM_EV_DONE     = 0;
  localparam int UWLM_EV_TLB_REFL = 1;
  localparam int UWLM_EV_TLB_INVL = 2;
  localparam int UWLM_EV_BUS_ERR  = 3;
  localparam int UWLM_EV_ADDR_ERR = 4;
  localparam int UWLM_EV_WATCH    = 5;
  localparam int UWLM_EV_RSVD     = 6;
  localparam int UWLM_EV_COP      = 7;

  // Merge constants
  localparam logic [31:0] UWLM_ALL_ONES  = 32'hffffffff;
  localparam logic [4:0]  UWLM_LEFT_BASE = 5'h18;

endpackage

// ==== verilog/uwlm_merge_unit.sv ====
// Partial-word load merge unit: address forming, fetch sequencing,
// byte merge, exception checks and an APB register block.
// Assumes the pipeline, translation and memory path share ref_clk.
// Functional notes
// - Left load address is base plus the sign-extended 16-bit offset.
// - Left load puts 1 to 4 top bytes of the word high, keeps the rest.
// - Right load address is base plus the sign-extended 16-bit offset.
// - Right load puts 1 to 4 low bytes of the word low, keeps the rest.
// - Left and right loads in either order leave the whole word, signed.
// - Bytes follow the address low two bits and the endian mode.
// - User-map left load adds a 9-bit signed offset, merges like left.
// - User-map left load uses user mapping in the mapped-user segment.
// - User-map left load exists only when enhanced addressing is present.
// - User-map left load needs system access and a user segment mode.
// - Normal loads need no alignment and raise only memory exceptions.
// - User-map left load may also raise reserved and unusable faults.
// - Upper 32 bits follow bit 31; no zero-extended form exists.
// - Back-to-back partial loads to one register merge correctly.
module uwlm_merge_unit
  import uwlm_pkg::*;
#(
  parameter int   REG_W       = 64,
  parameter logic EVA_PRESENT = 1'b1
) (
  input  wire logic              ref_clk,
  input  wire logic              nrst,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic                   pready,
  output logic [31:0]            prdata,
  output logic                   pslverr,
  // Request from the pipeline
  input  wire logic              req_valid,
  output logic                   req_ready,
  input  wire logic [1:0]        req_op,
  input  wire logic [31:0]       req_base,
  input  wire logic [15:0]       req_offset,
  input  wire logic [4:0]        req_dest_idx,
  input  wire logic [31:0]       req_dest_old,
  input  wire logic              cop0_access_en,
  input  wire logic [2:0]        seg_mode,
  // Memory and translation path
  output logic                   mem_req,
  output logic [31:0]            mem_addr,
  output logic                   mem_user_map,
  input  wire logic              mem_ack,
  input  wire logic [31:0]       mem_rdata,
  input  wire logic              mem_tlb_refill,
  input  wire logic              mem_tlb_invalid,
  input  wire logic              mem_bus_error,
  input  wire logic              mem_addr_error,
  input  wire logic              mem_watch,
  // Result to the register file
  output logic                   res_valid,
  output logic [REG_W-1:0]       res_data,
  output logic [4:0]             res_dest_idx,
  output logic                   res_exc,
  output logic [3:0]             res_exc_code,
  output logic                   irq
);

  typedef enum logic [2:0] {
    UWLM_ST_IDLE  = 3'b001,
    UWLM_ST_FETCH = 3'b010,
    UWLM_ST_SPARE = 3'b100
  } uwlm_st_type;

  typedef struct packed {
    uwlm_st_type            st;
    logic                   req_ready;
    uwlm_op_type            op;
    logic [4:0]             dest_idx;
    logic [31:0]            dest_old;
    logic [31:0]            eff_addr;
    logic                   mem_req;
    logic                   mem_user_map;
    logic                   res_valid;
    logic [REG_W-1:0]       res_data;
    logic [4:0]             res_dest_idx;
    logic                   res_exc;
    logic [3:0]             res_exc_code;
    logic                   ctrl_en;
    logic                   ctrl_big;
    logic [UWLM_EV_N-1:0]   sts;
    logic [UWLM_EV_N-1:0]   irq_en;
    logic                   irq;
    logic                   pready;
    logic [31:0]            prdata;
    logic                   pslverr;
  } uwlm_state_type;

  uwlm_state_type s_r;
  uwlm_state_type s_nxt;

  ////////////////////////////////////////////////////////////////////////
  // Merge helpers

  // Byte index from address low bits, flipped in big-endian mode
  function automatic logic [1:0] byte_index(input logic [1:0] lo,
                                            input logic       big);
    byte_index = lo ^ {2{big}};
  endfunction

  // Left merge: memory low bytes go to the top of the word
  function automatic logic [31:0] merge_left(input logic [31:0] mem,
                                             input logic [31:0] dst,
                                             input logic [1:0]  idx);
    logic [4:0]  sh;
    logic [31:0] keep;
    sh         = UWLM_LEFT_BASE - {idx, 3'h0};
    keep       = ~(UWLM_ALL_ONES << sh);
    merge_left = (mem << sh) | (dst & keep);
  endfunction

  // Right merge: memory high bytes go to the bottom of the word
  function automatic logic [31:0] merge_right(input logic [31:0] mem,
                                              input logic [31:0] dst,
                                              input logic [1:0]  idx);
    logic [4:0]  sh;
    logic [31:0] keep;
    sh          = {idx, 3'h0};
    keep        = ~(UWLM_ALL_ONES >> sh);
    merge_right = (mem >> sh) | (dst & keep);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Request decode, combinational

  logic [31:0]          ofs_ext;
  logic [31:0]          eff_addr;
  logic [31:0]          dest_src;
  logic                 user_op;
  logic                 user_seg_ok;
  logic [3:0]           pre_exc;
  logic [3:0]           mem_exc;
  logic [31:0]          merged;
  logic [UWLM_EV_N-1:0] ev;

  // Offset width depends on the flavour of the load
  always_comb begin
    user_op = (req_op == UWLM_OP_USER_LEFT);
    if (user_op) begin
      ofs_ext = {{(32-UWLM_USER_OFS_W){req_offset[UWLM_USER_OFS_W-1]}},
                 req_offset[UWLM_USER_OFS_W-1:0]};
    end else begin
      ofs_ext = {{(32-UWLM_OFS_W){req_offset[UWLM_OFS_W-1]}},
                 req_offset};
    end
    eff_addr = req_base + ofs_ext;
  end

  // Forward a result still on its way to the register file
  always_comb begin
    if (s_r.res_valid && !s_r.res_exc &&
        s_r.res_dest_idx == req_dest_idx) begin
      dest_src = s_r.res_data[31:0];
    end else begin
      dest_src = req_dest_old;
    end
  end

  // Checks done before any fetch; no alignment check at all
  always_comb begin
    user_seg_ok = (seg_mode == UWLM_SEG_MAPPED_USER)  ||
                  (seg_mode == UWLM_SEG_UNMAPPED_USR) ||
                  (seg_mode == UWLM_SEG_MAPPED_SUPV);
    pre_exc = UWLM_EXC_NONE;
    if (user_op && !EVA_PRESENT) begin
      pre_exc = UWLM_EXC_RSVD_INST;
    end else if (user_op && !cop0_access_en) begin
      pre_exc = UWLM_EXC_COP_UNUSE;
    end else if (user_op && !user_seg_ok) begin
      pre_exc = UWLM_EXC_ADDR_ERR;
    end else if (req_op != UWLM_OP_LEFT && req_op != UWLM_OP_RIGHT &&
                 !user_op) begin
      pre_exc = UWLM_EXC_RSVD_INST; // Unknown operation code
    end
  end

  // Fault priority follows the order of the translation pipeline
  always_comb begin
    mem_exc = UWLM_EXC_NONE;
    if (mem_tlb_refill) begin
      mem_exc = UWLM_EXC_TLB_REFL;
    end else if (mem_tlb_invalid) begin
      mem_exc = UWLM_EXC_TLB_INVL;
    end else if (mem_addr_error) begin
      mem_exc = UWLM_EXC_ADDR_ERR;
    end else if (mem_watch) begin
      mem_exc = UWLM_EXC_WATCH;
    end else if (mem_bus_error) begin
      mem_exc = UWLM_EXC_BUS_ERR;
    end
  end

  // Byte merge into the captured destination word
  always_comb begin
    if (s_r.op == UWLM_OP_RIGHT) begin
      merged = merge_right(mem_rdata, s_r.dest_old,
                           byte_index(s_r.eff_addr[1:0], s_r.ctrl_big));
    end else begin
      merged = merge_left(mem_rdata, s_r.dest_old,
                          byte_index(s_r.eff_addr[1:0], s_r.ctrl_big));
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    s_nxt           = s_r;
    s_nxt.res_valid = 1'b0;
    ev              = '0;

    unique case (s_r.st)
      UWLM_ST_IDLE: begin
        if (req_valid && s_r.req_ready) begin
          s_nxt.op       = uwlm_op_type'(req_op);
          s_nxt.dest_idx = req_dest_idx;
          s_nxt.dest_old = dest_src;
          s_nxt.eff_addr = eff_addr;
          if (pre_exc != UWLM_EXC_NONE) begin
            // Refused before memory is touched
            s_nxt.res_valid    = 1'b1;
            s_nxt.res_exc      = 1'b1;
            s_nxt.res_exc_code = pre_exc;
            s_nxt.res_dest_idx = req_dest_idx;
            ev[UWLM_EV_RSVD]     = (pre_exc == UWLM_EXC_RSVD_INST);
            ev[UWLM_EV_COP]      = (pre_exc == UWLM_EXC_COP_UNUSE);
            ev[UWLM_EV_ADDR_ERR] = (pre_exc == UWLM_EXC_ADDR_ERR);
          end else begin
            s_nxt.st           = UWLM_ST_FETCH;
            s_nxt.req_ready    = 1'b0;
            s_nxt.mem_req      = 1'b1;
            s_nxt.mem_user_map = user_op &&
                                 (seg_mode == UWLM_SEG_MAPPED_USER);
          end
        end
        s_nxt.req_ready = (s_nxt.st == UWLM_ST_IDLE) && s_r.ctrl_en;
      end
      UWLM_ST_FETCH: begin
        if (mem_ack) begin
          s_nxt.st           = UWLM_ST_IDLE;
          s_nxt.mem_req      = 1'b0;
          s_nxt.mem_user_map = 1'b0;
          s_nxt.req_ready    = s_r.ctrl_en;
          s_nxt.res_valid    = 1'b1;
          s_nxt.res_dest_idx = s_r.dest_idx;
          s_nxt.res_exc_code = mem_exc;
          s_nxt.res_exc      = (mem_exc != UWLM_EXC_NONE);
          // Sign extension from bit 31, never zero fill
          s_nxt.res_data = {{(REG_W-32){merged[31]}}, merged};
          ev[UWLM_EV_DONE]     = (mem_exc == UWLM_EXC_NONE);
          ev[UWLM_EV_TLB_REFL] = (mem_exc == UWLM_EXC_TLB_REFL);
          ev[UWLM_EV_TLB_INVL] = (mem_exc == UWLM_EXC_TLB_INVL);
          ev[UWLM_EV_BUS_ERR]  = (mem_exc == UWLM_EXC_BUS_ERR);
          ev[UWLM_EV_ADDR_ERR] = (mem_exc == UWLM_EXC_ADDR_ERR);
          ev[UWLM_EV_WATCH]    = (mem_exc == UWLM_EXC_WATCH);
        end
      end
      default: begin
        // Illegal code: recover to idle
        s_nxt.st        = UWLM_ST_IDLE;
        s_nxt.mem_req   = 1'b0;
        s_nxt.req_ready = 1'b0;
      end
    endcase

    // APB: one wait state, read data captured one edge before completion, write at the completing edge
    s_nxt.pready  = psel && penable && !s_r.pready;
    s_nxt.pslverr = 1'b0;
    if (psel && penable && !s_r.pready) begin
      s_nxt.prdata = 32'h00000000;
      unique case (paddr)
        UWLM_ADDR_CTRL: begin
          s_nxt.prdata[UWLM_CTRL_EN_BIT]  = s_r.ctrl_en;
          s_nxt.prdata[UWLM_CTRL_BIG_BIT] = s_r.ctrl_big;
        end
        UWLM_ADDR_STATUS: s_nxt.prdata[UWLM_EV_N-1:0] = s_r.sts;
        UWLM_ADDR_IRQ_EN: s_nxt.prdata[UWLM_EV_N-1:0] = s_r.irq_en;
        UWLM_ADDR_CLEAR:  s_nxt.prdata = 32'h00000000;
        UWLM_ADDR_LAST:   s_nxt.prdata = s_r.eff_addr;
        UWLM_ADDR_CONFIG: s_nxt.prdata[0] = EVA_PRESENT;
        default:          s_nxt.pslverr = 1'b1;
      endcase
    end
    if (psel && penable && s_r.pready && pwrite) begin
      unique case (paddr)
        UWLM_ADDR_CTRL: begin
          s_nxt.ctrl_en  = pwdata[UWLM_CTRL_EN_BIT];
          s_nxt.ctrl_big = pwdata[UWLM_CTRL_BIG_BIT];
        end
        UWLM_ADDR_IRQ_EN: s_nxt.irq_en = pwdata[UWLM_EV_N-1:0];
        UWLM_ADDR_CLEAR:  s_nxt.sts = s_r.sts & ~pwdata[UWLM_EV_N-1:0];
        default: ;
      endcase
      if (paddr == UWLM_ADDR_CTRL && s_nxt.st == UWLM_ST_IDLE) begin
        s_nxt.req_ready = pwdata[UWLM_CTRL_EN_BIT];
      end
    end

    // New events win over a clear in the same cycle
    s_nxt.sts = s_nxt.sts | ev;
    s_nxt.irq = |(s_nxt.sts & s_nxt.irq_en);
  end

  ////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      s_r              <= '0;
      s_r.st           <= UWLM_ST_IDLE;
      s_r.op           <= UWLM_OP_LEFT;
      s_r.ctrl_en      <= UWLM_CTRL_EN_RST;
      s_r.ctrl_big     <= UWLM_CTRL_BIG_RST;
      s_r.req_ready    <= UWLM_CTRL_EN_RST;
      s_r.res_exc_code <= UWLM_EXC_NONE;
    end else begin
      s_r <= s_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs, all straight from the state register

  assign pready       = s_r.pready;
  assign prdata       = s_r.prdata;
  assign pslverr      = s_r.pslverr;
  assign req_ready    = s_r.req_ready;
  assign mem_req      = s_r.mem_req;
  assign mem_addr     = {s_r.eff_addr[31:2], 2'h0};
  assign mem_user_map = s_r.mem_user_map;
  assign res_valid    = s_r.res_valid;
  assign res_data     = s_r.res_data;
  assign res_dest_idx = s_r.res_dest_idx;
  assign res_exc      = s_r.res_exc;
  assign res_exc_code = s_r.res_exc_code;
  assign irq          = s_r.irq;

endmodule

// ==== bench/uwlm_assertions.sv ====
// Checker of the merge unit ports: fetch address, checks, results.
// Assumes a bind from the bench top; sees top-level ports only.
module uwlm_chk
  import uwlm_pkg::*;
#(
  parameter int   REG_W       = 64,
  parameter logic EVA_PRESENT = 1'b1
) (
  input wire logic             ref_clk,
  input wire logic             nrst,
  input wire logic             req_valid,
  input wire logic             req_ready,
  input wire logic [1:0]       req_op,
  input wire logic [31:0]      req_base,
  input wire logic [15:0]      req_offset,
  input wire logic             cop0_access_en,
  input wire logic [2:0]       seg_mode,
  input wire logic             mem_req,
  input wire logic [31:0]      mem_addr,
  input wire logic             mem_user_map,
  input wire logic             mem_ack,
  input wire logic             mem_tlb_refill,
  input wire logic             res_valid,
  input wire logic [REG_W-1:0] res_data,
  input wire logic             res_exc,
  input wire logic [3:0]       res_exc_code
);
  timeunit 1ns;
  timeprecision 1ns;
  logic        tk;
  logic        uok;
  logic [31:0] ea16;
  logic [31:0] ea9;
  ////////////////////////////////////////
  // Take and both address forms, seen from the request side
  assign tk   = req_valid && req_ready;
  assign ea16 = req_base + {{16{req_offset[15]}}, req_offset};
  assign ea9  = req_base + {{23{req_offset[8]}}, req_offset[8:0]};
  assign uok  = EVA_PRESENT && cop0_access_en && seg_mode >= 3'h1
                && seg_mode <= 3'h3;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  ////////////////////////////////////////
  property p_fetch; tk && req_op < 2'h2 |=>
    mem_req && mem_addr == ($past(ea16) & 32'hfffffffc); endproperty
  property p_uaddr; tk && req_op == 2'h2 && uok |=>
    mem_req && mem_addr == ($past(ea9) & 32'hfffffffc); endproperty
  property p_umap; tk && req_op == 2'h2 && uok |=>
    mem_user_map == ($past(seg_mode) == UWLM_SEG_MAPPED_USER); endproperty
  property p_rsvd; tk && (req_op == 2'h3 || req_op == 2'h2 && !EVA_PRESENT)
    |=> res_valid && res_exc_code == UWLM_EXC_RSVD_INST && !mem_req;
  endproperty
  property p_cop; tk && req_op == 2'h2 && EVA_PRESENT && !cop0_access_en
    |=> res_valid && res_exc && res_exc_code == UWLM_EXC_COP_UNUSE;
  endproperty
  property p_answer; mem_req && mem_ack |=> res_valid && !mem_req;
  endproperty
  property p_refill; mem_req && mem_ack && mem_tlb_refill |=>
    res_exc && res_exc_code == UWLM_EXC_TLB_REFL; endproperty
  property p_sext; res_valid && !res_exc |->
    res_data[REG_W-1:32] == {(REG_W-32){res_data[31]}}; endproperty
  // All but a_answer fire on a wrong figure, not only on a missing pulse
  a_fetch: assert property (p_fetch) else $error("bad fetch");
  a_uaddr: assert property (p_uaddr) else $error("bad user addr");
  a_umap: assert property (p_umap) else $error("bad user map");
  a_rsvd: assert property (p_rsvd) else $error("no reserved");
  a_cop: assert property (p_cop) else $error("no unusable");
  a_answer: assert property (p_answer) else $error("late result");
  a_refill: assert property (p_refill) else $error("bad fault");
  a_sext: assert property (p_sext) else $error("not signed");
  c_left: cover property (tk && req_op == 2'h0);
  c_user: cover property (tk && req_op == 2'h2 && uok);
  c_fault: cover property (mem_ack && mem_tlb_refill);
endmodule

// ==== bench/uwlm_mem_model.sv ====
// Memory and translation side of the merge unit, behavioural.
// Assumes one clock; answers a held fetch after dly wait cycles.
module uwlm_mem_model (
  input  wire logic        ref_clk,
  input  wire logic        nrst,
  input  wire logic        mem_req,
  input  wire logic [31:0] mem_addr,
  input  wire logic [3:0]  dly,
  input  wire logic [2:0]  flt,
  output logic             mem_ack,
  output logic [31:0]      mem_rdata,
  output logic             mem_tlb_refill,
  output logic             mem_tlb_invalid,
  output logic             mem_bus_error,
  output logic             mem_addr_error,
  output logic             mem_watch
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0]  cnt;
  logic [31:0] word;
  ////////////////////////////////////////
  // Data inverted off the answer cycle, so stale data never matches
  assign word = {mem_addr[31:2], 2'h0} ^ 32'h5a3c96e1;
  assign mem_rdata = mem_ack ? word : ~word;
  // Faults ride only on the answer cycle
  assign mem_tlb_refill  = mem_ack && flt == 3'h1;
  assign mem_tlb_invalid = mem_ack && flt == 3'h2;
  assign mem_bus_error   = mem_ack && flt == 3'h3;
  assign mem_addr_error  = mem_ack && flt == 3'h4;
  assign mem_watch       = mem_ack && flt == 3'h5;
  // One answer per fetch, after the chosen wait
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      mem_ack <= 1'b0;
      cnt <= 4'h0;
    end else if (mem_ack || !mem_req) begin
      mem_ack <= 1'b0;
      cnt <= 4'h0;
    end else if (cnt >= dly) begin
      mem_ack <= 1'b1;
    end else begin
      cnt <= cnt + 4'h1;
    end
  end
endmodule

// ==== bench/uwlm_merge_unit_test.sv ====
// Bench of the merge unit: APB master, request driver, memory model.
// Assumes the design package and default REG_W of 64.
module uwlm_merge_unit_test
  import uwlm_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [31:0] OLD = 32'h13579bdf;
  logic        ref_clk, nrst, psel, penable, pwrite, pready, pslverr;
  logic        req_valid, req_ready, cop0_access_en, mem_req, mem_ack;
  logic        mem_user_map, res_valid, res_exc, irq, er;
  logic        mem_tlb_refill, mem_tlb_invalid, mem_bus_error;
  logic        mem_addr_error, mem_watch;
  logic [1:0]  req_op;
  logic [2:0]  seg_mode, flt;
  logic [3:0]  res_exc_code, dly, c;
  logic [4:0]  req_dest_idx, res_dest_idx;
  logic [7:0]  paddr;
  logic [15:0] req_offset;
  logic [31:0] pwdata, prdata, req_base, req_dest_old, mem_addr;
  logic [31:0] mem_rdata, rd, ea;
  logic [63:0] res_data, d;
  int          error_cnt, total_checks, cyc;
  ////////////////////////////////////////
  uwlm_merge_unit u_uwlm_merge_unit (.ref_clk, .nrst, .psel, .penable,
    .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr, .req_valid,
    .req_ready, .req_op, .req_base, .req_offset, .req_dest_idx,
    .req_dest_old, .cop0_access_en, .seg_mode, .mem_req, .mem_addr,
    .mem_user_map, .mem_ack, .mem_rdata, .mem_tlb_refill, .mem_tlb_invalid,
    .mem_bus_error, .mem_addr_error, .mem_watch, .res_valid, .res_data,
    .res_dest_idx, .res_exc, .res_exc_code, .irq);
  uwlm_mem_model u_uwlm_mem_model (.ref_clk, .nrst, .mem_req, .mem_addr,
    .dly, .flt, .mem_ack, .mem_rdata, .mem_tlb_refill, .mem_tlb_invalid,
    .mem_bus_error, .mem_addr_error, .mem_watch);
  // Clock, 50 ns period
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  // Hang guard, far above the few hundred cycles the run needs
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      $display("unexpected at %0t: timeout", $time);
      stop_test;
    end
  end
  ////////////////////////////////////////
  // Expected values, worked out byte by byte
  function automatic logic [31:0] mw(logic [31:0] a);
    return {a[31:2], 2'h0} ^ 32'h5a3c96e1;
  endfunction
  function automatic logic [63:0] sx(logic [31:0] r);
    return {{32{r[31]}}, r};
  endfunction
  function automatic logic [31:0] lm(logic [31:0] m, o, logic [1:0] k);
    return (m << (24 - 8 * k)) | (o & ((32'h1 << (24 - 8 * k)) - 1));
  endfunction
  function automatic logic [31:0] rm(logic [31:0] m, o, logic [1:0] k);
    return (m >> (8 * k)) | (o & ~(32'hffffffff >> (8 * k)));
  endfunction
  function automatic logic [7:0] bt(logic [31:0] a);
    logic [31:0] w;
    w = mw(a);
    return w[31 - 8 * a[1:0] -: 8];
  endfunction
  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    total_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask
  // APB transfer; held until pready is seen at an edge
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] wd);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic drv(input logic [1:0] op, input logic [31:0] b,
                     input logic [15:0] o, input logic [31:0] od);
    req_valid <= 1'b1;
    req_op <= op;
    req_base <= b;
    req_offset <= o;
    req_dest_old <= od;
  endtask
  task automatic take;
    do @(posedge ref_clk); while (req_ready !== 1'b1);
    req_valid <= 1'b0;
  endtask
  task automatic fin;
    do @(posedge ref_clk); while (res_valid !== 1'b1);
    d = res_data;
    c = res_exc_code;
    chk(res_dest_idx, req_dest_idx);
  endtask
  task automatic ld(input logic [1:0] op, input logic [31:0] b,
                    input logic [15:0] o);
    @(posedge ref_clk);
    drv(op, b, o, OLD);
    take;
    fin;
  endtask
  ////////////////////////////////////////
  task automatic t_regs;
    apb(1'b0, UWLM_ADDR_CTRL, 32'h0);
    chk(rd, 32'h3);
    apb(1'b0, UWLM_ADDR_CONFIG, 32'h0);
    chk(rd[0], 1'b1);
    apb(1'b0, 8'h18, 32'h0);
    chk(er, 1'b1);
    $display("test regs done");
  endtask
  // Every offset in both byte orders, with prompt and slow answers
  task automatic t_merge;
    for (int b = 0; b < 2; b++) begin
      apb(1'b1, UWLM_ADDR_CTRL, {30'h0, b[0], 1'b1});
      for (int a = 0; a < 4; a++) begin
        dly <= a[3:0];
        ea = 32'h100000fc + a;
        ld(UWLM_OP_LEFT, 32'h10000100 + a, 16'hfffc);
        chk(d, sx(lm(mw(ea), OLD, ea[1:0] ^ {b[0], b[0]})));
        ld(UWLM_OP_RIGHT, 32'h10000100 + a, 16'hfffc);
        chk(d, sx(rm(mw(ea), OLD, ea[1:0] ^ {b[0], b[0]})));
      end
    end
    $display("test merge done");
  endtask
  // Right load taken in the result cycle of the left load
  task automatic t_pair;
    apb(1'b1, UWLM_ADDR_CTRL, 32'h3);
    ea = 32'h20000201;
    @(posedge ref_clk);
    drv(UWLM_OP_LEFT, ea, 16'h0, 32'h0);
    take;
    do @(posedge ref_clk); while (!(mem_req === 1'b1 && mem_ack === 1'b1));
    drv(UWLM_OP_RIGHT, ea, 16'h3, 32'hdeadbeef);
    take;
    fin;
    chk(d, sx({bt(ea), bt(ea + 1), bt(ea + 2), bt(ea + 3)}));
    $display("test pair done");
  endtask
  // User-map load over the three user modes, then two of its refusals and an unknown code
  task automatic t_user;
    cop0_access_en <= 1'b1;
    ea = 32'h300000fd;
    for (int s = 1; s < 4; s++) begin
      seg_mode <= s[2:0];
      ld(UWLM_OP_USER_LEFT, 32'h30000105, 16'h01f8);
      chk(d, sx(lm(mw(ea), OLD, ea[1:0] ^ 2'h3)));
    end
    seg_mode <= 3'h0;
    ld(UWLM_OP_USER_LEFT, 32'h30000105, 16'h01f8);
    chk(c, UWLM_EXC_ADDR_ERR);
    seg_mode <= 3'h1;
    cop0_access_en <= 1'b0;
    ld(UWLM_OP_USER_LEFT, 32'h30000105, 16'h01f8);
    chk(c, UWLM_EXC_COP_UNUSE);
    ld(2'h3, 32'h30000105, 16'h0);
    chk(c, UWLM_EXC_RSVD_INST);
    $display("test user done");
  endtask
  task automatic t_fault;
    for (int f = 1; f < 6; f++) begin
      flt <= f[2:0];
      ld(UWLM_OP_LEFT, 32'h40000002, 16'h0);
      chk(c, f[3:0]);
    end
    flt <= 3'h0;
    $display("test fault done");
  endtask
  // Masked, enabled and cleared interrupt
  task automatic t_irq;
    apb(1'b1, UWLM_ADDR_IRQ_EN, 32'h0);
    repeat (2) @(posedge ref_clk);
    chk(irq, 1'b0);
    apb(1'b1, UWLM_ADDR_IRQ_EN, 32'h2);
    repeat (2) @(posedge ref_clk);
    chk(irq, 1'b1);
    apb(1'b0, UWLM_ADDR_STATUS, 32'h0);
    chk(rd, 32'hff);
    apb(1'b1, UWLM_ADDR_CLEAR, 32'hff);
    apb(1'b0, UWLM_ADDR_STATUS, 32'h0);
    chk(rd, 32'h0);
    chk(irq, 1'b0);
    apb(1'b0, UWLM_ADDR_LAST, 32'h0);
    chk(rd, 32'h40000002);
    // Disabled unit refuses requests
    apb(1'b1, UWLM_ADDR_CTRL, 32'h2);
    @(posedge ref_clk);
    chk(req_ready, 1'b0);
    $display("test irq done");
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    {nrst, psel, penable, pwrite, req_valid, paddr, pwdata} = '0;
    {req_op, req_base, req_offset, req_dest_old, dly, flt} = '0;
    cop0_access_en = 1'b1;
    seg_mode = 3'h1;
    req_dest_idx = 5'h3;
    repeat (16) @(posedge ref_clk);
    nrst <= 1'b1;
    t_regs;
    t_merge;
    t_pair;
    t_user;
    t_fault;
    t_irq;
    stop_test;
  end
endmodule
////////////////////////////////////////
bind uwlm_merge_unit uwlm_chk #(.REG_W(REG_W), .EVA_PRESENT(EVA_PRESENT))
  u_uwlm_chk (.ref_clk, .nrst, .req_valid, .req_ready, .req_op, .req_base,
  .req_offset, .cop0_access_en, .seg_mode, .mem_req, .mem_addr,
  .mem_user_map, .mem_ack, .mem_tlb_refill, .res_valid, .res_data,
  .res_exc, .res_exc_code);
